/* sac_analog_model.sv */
// behavioural analog front end: input mux and comparator
`timescale 1ns/10ps

module sac_analog_model (
	input wire logic [79:0] levels, // ten-bit level of each analog input
	input wire logic [7:0] channel_sel, // one-hot routing from the block
	input wire logic [9:0] dac_code, // trial code from the block
	output logic comp_out // high while selected level >= trial
);
	logic [9:0] sel_level;
	// no routed input leaves the comparator seeing zero volts
	always_comb begin
		sel_level = 10'h000;
		for (int i = 0; i < 8; i++) begin
			if (channel_sel[i]) begin
				sel_level = levels[i*10 +: 10];
			end
		end
	end
	assign comp_out = (sel_level >= dac_code);
endmodule

/* sac_consts.svh */
// register map, field positions, reset values and timing counts
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_OFS_MODE 8'h00
`define SAC_OFS_START 8'h04
`define SAC_OFS_RES_HIGH 8'h08
`define SAC_OFS_RES_LOW 8'h0c
`define SAC_OFS_CLK_STOP 8'h10
`define SAC_OFS_EDGE_SEL 8'h14
`define SAC_OFS_PORT_MODE 8'h18
`define SAC_OFS_IRQ_REQ 8'h1c
`define SAC_OFS_IRQ_EN 8'h20

`define SAC_RST_MODE 8'h30
`define SAC_RST_CLK_STOP 8'hff
`define SAC_RST_EDGE_SEL 8'h00
`define SAC_RST_PORT_MODE 8'h00

`define SAC_MODE_FIXED_ONES 8'h30
`define SAC_START_FIXED_ONES 8'h7f

`define SAC_BIT_SPEED 7
`define SAC_BIT_TRIG_EN 6
`define SAC_BIT_START_FLAG 7
`define SAC_BIT_MODULE_STOP 4
`define SAC_BIT_EDGE_SEL 4
`define SAC_BIT_TRIG_FUNC 4
`define SAC_BIT_END_REQ 3

`define SAC_PERIOD_SLOW 6'h3e
`define SAC_PERIOD_FAST 6'h1f
`define SAC_RESULT_BITS 10

`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

/* sac_conv_ctrl.sv */
// converter control top: register file over axi4-lite and sequencing
//
// Summary of operation
// - writing one to the start flag begins a conversion
// - selected trigger pin edge sets the start flag and starts conversion
// - on completion load both result registers and clear flag together
// - start flag reads one while converting, zero otherwise, resets zero
// - writing zero to the start flag aborts conversion and goes idle
// - start register bits six to zero read one, writes ignored
// - module-stop bit four: zero is standby, one runs; resets to one
// - successive approximation yields a ten-bit result per conversion
// - completion sets end request flag; interrupt only when enabled
// - trigger edges count only with pin function and trigger enable set
// - edge select bit chooses rising or falling trigger edges
// - mode and start registers reset, work, and hold when frozen
// - result registers survive ordinary reset and low-power modes
// - channel code 0101 routes analog input one
// - after completion a new start repeats the whole sequence
// - channel codes: 00xx none, 01xx inputs 0-3, 10xx inputs 4-7
// - speed bit selects 62 clocks when zero, 31 when one
// - upper eight result bits high, lower two at top of low
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_conv_ctrl (
	input wire logic CLK_SYS, // system clock, 200 MHz
	input wire logic RST_N, // synchronous reset, active low
	input wire logic CE, // clock enable, freezes all state when low
	input wire logic [7:0] S_AXI_AWADDR, // write address
	input wire logic S_AXI_AWVALID, // write address valid
	output logic S_AXI_AWREADY, // write address ready
	input wire logic [31:0] S_AXI_WDATA, // write data
	input wire logic [3:0] S_AXI_WSTRB, // write byte enables
	input wire logic S_AXI_WVALID, // write data valid
	output logic S_AXI_WREADY, // write data ready
	output logic [1:0] S_AXI_BRESP, // write response
	output logic S_AXI_BVALID, // write response valid
	input wire logic S_AXI_BREADY, // write response ready
	input wire logic [7:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	output logic S_AXI_ARREADY, // read address ready
	output logic [31:0] S_AXI_RDATA, // read data
	output logic [1:0] S_AXI_RRESP, // read response
	output logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_RREADY, // read data ready
	input wire logic EXT_TRIGGER_PIN, // external trigger input
	input wire logic COMP_IN, // comparator result from analog part
	output logic [9:0] DAC_CODE, // trial code to the analog part
	output logic [7:0] CHANNEL_SEL, // one-hot analog input routing
	output logic CONV_MODULE_STANDBY, // converter held in standby
	output logic CONV_END_IRQ // conversion end interrupt request
);

	// register state
	logic [7:0] mode_reg;
	logic conv_start_flag_reg;
	sac_pkg::sac_result_s result_reg;
	logic [7:0] clk_stop_reg;
	logic [7:0] edge_sel_reg;
	logic [7:0] port_mode_reg;
	logic conv_end_request_flag_reg;
	logic conv_end_irq_enable_reg;

	// bus state
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic w_strobe_reg;

	// named fields
	logic conv_speed_select;
	logic ext_trigger_enable;
	logic [3:0] input_channel_select;
	logic conv_module_stop_bit;
	logic trigger_edge_select;
	logic trigger_pin_function;

	// write decode
	sac_pkg::sac_wreq_s wreq;
	logic wr_fire;
	logic wr_en;
	logic wr_mode;
	logic wr_start;
	logic wr_clk_stop;
	logic wr_edge_sel;
	logic wr_port_mode;
	logic wr_irq_req;
	logic wr_irq_en;
	logic wr_mapped;

	// read decode
	logic rd_fire;
	logic [7:0] rd_byte;
	logic rd_mapped;

	// sequencing
	logic in_standby;
	logic sw_start;
	logic sw_abort;
	logic trig_pulse;
	logic trig_start;
	logic conv_start;
	logic conv_done;
	logic [9:0] conv_code;
	logic [9:0] dac_trial;
	logic [7:0] channel_next;
	logic chan_lo_group;
	logic chan_hi_group;
	logic irq_next;

	assign conv_speed_select = mode_reg[`SAC_BIT_SPEED];
	assign ext_trigger_enable = mode_reg[`SAC_BIT_TRIG_EN];
	assign input_channel_select = mode_reg[3:0];
	assign conv_module_stop_bit = clk_stop_reg[`SAC_BIT_MODULE_STOP];
	assign trigger_edge_select = edge_sel_reg[`SAC_BIT_EDGE_SEL];
	assign trigger_pin_function = port_mode_reg[`SAC_BIT_TRIG_FUNC];

	// write channel: address and data taken in either order
	assign wreq.addr = aw_addr_reg;
	assign wreq.data = w_data_reg;
	assign wreq.strobe = w_strobe_reg;
	assign wr_fire = aw_held_reg & w_held_reg & ~S_AXI_BVALID;
	assign wr_en = wr_fire & wreq.strobe;
	assign wr_mode = wr_en & (wreq.addr == `SAC_OFS_MODE);
	assign wr_start = wr_en & (wreq.addr == `SAC_OFS_START);
	assign wr_clk_stop = wr_en & (wreq.addr == `SAC_OFS_CLK_STOP);
	assign wr_edge_sel = wr_en & (wreq.addr == `SAC_OFS_EDGE_SEL);
	assign wr_port_mode = wr_en & (wreq.addr == `SAC_OFS_PORT_MODE);
	assign wr_irq_req = wr_en & (wreq.addr == `SAC_OFS_IRQ_REQ);
	assign wr_irq_en = wr_en & (wreq.addr == `SAC_OFS_IRQ_EN);
	assign wr_mapped = (wreq.addr == `SAC_OFS_MODE) |
		(wreq.addr == `SAC_OFS_START) |
		(wreq.addr == `SAC_OFS_RES_HIGH) |
		(wreq.addr == `SAC_OFS_RES_LOW) |
		(wreq.addr == `SAC_OFS_CLK_STOP) |
		(wreq.addr == `SAC_OFS_EDGE_SEL) |
		(wreq.addr == `SAC_OFS_PORT_MODE) |
		(wreq.addr == `SAC_OFS_IRQ_REQ) |
		(wreq.addr == `SAC_OFS_IRQ_EN);

	// read channel
	assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
	assign rd_mapped = wr_mapped_rd(S_AXI_ARADDR);

	function automatic logic wr_mapped_rd(input logic [7:0] a);
		wr_mapped_rd = (a == `SAC_OFS_MODE) | (a == `SAC_OFS_START) |
			(a == `SAC_OFS_RES_HIGH) | (a == `SAC_OFS_RES_LOW) |
			(a == `SAC_OFS_CLK_STOP) | (a == `SAC_OFS_EDGE_SEL) |
			(a == `SAC_OFS_PORT_MODE) | (a == `SAC_OFS_IRQ_REQ) |
			(a == `SAC_OFS_IRQ_EN);
	endfunction

	always_comb begin
		rd_byte = 8'h00;
		case (S_AXI_ARADDR)
			`SAC_OFS_MODE: rd_byte = mode_reg | `SAC_MODE_FIXED_ONES;
			`SAC_OFS_START:
				rd_byte = {conv_start_flag_reg, 7'h00} |
					`SAC_START_FIXED_ONES;
			`SAC_OFS_RES_HIGH: rd_byte = result_reg.high;
			`SAC_OFS_RES_LOW: rd_byte = {result_reg.low, 6'h00};
			`SAC_OFS_CLK_STOP: rd_byte = clk_stop_reg;
			`SAC_OFS_EDGE_SEL: rd_byte = edge_sel_reg;
			`SAC_OFS_PORT_MODE: rd_byte = port_mode_reg;
			`SAC_OFS_IRQ_REQ:
				rd_byte = {4'h0, conv_end_request_flag_reg, 3'h0};
			`SAC_OFS_IRQ_EN:
				rd_byte = {4'h0, conv_end_irq_enable_reg, 3'h0};
			default: rd_byte = 8'h00;
		endcase
	end

	// start and abort requests
	assign in_standby = ~conv_module_stop_bit;
	assign sw_start = wr_start & wreq.data[`SAC_BIT_START_FLAG] &
		~conv_start_flag_reg & ~in_standby;
	assign sw_abort = wr_start & ~wreq.data[`SAC_BIT_START_FLAG];
	assign trig_start = trig_pulse & ~conv_start_flag_reg & ~in_standby &
		~wr_start;
	assign conv_start = sw_start | trig_start;

	// one-hot routing, 00xx and 11xx select nothing
	assign chan_lo_group = (input_channel_select[3:2] == 2'b01);
	assign chan_hi_group = (input_channel_select[3:2] == 2'b10);

	generate
		for (genvar gi = 0; gi < 4; gi++) begin : g_chan
			assign channel_next[gi] = chan_lo_group &
				(input_channel_select[1:0] == 2'(gi));
			assign channel_next[gi + 4] = chan_hi_group &
				(input_channel_select[1:0] == 2'(gi));
		end
	endgenerate

	// interrupt line follows request flag gated by its enable
	assign irq_next = (conv_end_request_flag_reg | conv_done) &
		conv_end_irq_enable_reg;

	sac_trigger_edge u_trigger (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.ce(CE),
		.pin(EXT_TRIGGER_PIN),
		.rising_sel(trigger_edge_select),
		.enable(trigger_pin_function & ext_trigger_enable),
		.edge_pulse(trig_pulse)
	);

	sac_sar_engine u_sar (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.ce(CE),
		.start(conv_start),
		.abort(sw_abort | in_standby),
		.fast(conv_speed_select),
		.comp_in(COMP_IN),
		.trial(dac_trial),
		.done(conv_done),
		.code(conv_code)
	);

	// axi write address and write data capture, in either order
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 8'h00;
			w_strobe_reg <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end else if (CE) begin
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
			end else if (wr_fire)
				aw_held_reg <= 1'b0;
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA[7:0];
				w_strobe_reg <= S_AXI_WSTRB[0];
			end else if (wr_fire)
				w_held_reg <= 1'b0;
			S_AXI_AWREADY <= ~aw_held_reg & ~S_AXI_AWREADY;
			S_AXI_WREADY <= ~w_held_reg & ~S_AXI_WREADY;
		end
	end

	// axi write response, held until bready
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `SAC_RESP_OKAY;
		end else if (CE) begin
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_mapped ? `SAC_RESP_OKAY :
					`SAC_RESP_SLVERR;
			end else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// axi read: address taken only while no answer is pending
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP <= `SAC_RESP_OKAY;
			S_AXI_RDATA <= 32'h0000_0000;
		end else if (CE) begin
			S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY &
				~S_AXI_RVALID;
			if (rd_fire) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= {24'h000000, rd_byte};
				S_AXI_RRESP <= rd_mapped ? `SAC_RESP_OKAY :
					`SAC_RESP_SLVERR;
			end else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	// control registers
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			mode_reg <= `SAC_RST_MODE;
			conv_start_flag_reg <= 1'b0;
			clk_stop_reg <= `SAC_RST_CLK_STOP;
			edge_sel_reg <= `SAC_RST_EDGE_SEL;
			port_mode_reg <= `SAC_RST_PORT_MODE;
			conv_end_request_flag_reg <= 1'b0;
			conv_end_irq_enable_reg <= 1'b0;
		end else if (CE) begin
			if (wr_mode)
				mode_reg <= wreq.data | `SAC_MODE_FIXED_ONES;
			if (wr_clk_stop)
				clk_stop_reg <= wreq.data;
			if (wr_edge_sel)
				edge_sel_reg <= wreq.data;
			if (wr_port_mode)
				port_mode_reg <= wreq.data;
			if (wr_irq_en)
				conv_end_irq_enable_reg <= wreq.data[`SAC_BIT_END_REQ];
			// set by completion wins over a software clear
			if (conv_done)
				conv_end_request_flag_reg <= 1'b1;
			else if (wr_irq_req & ~wreq.data[`SAC_BIT_END_REQ])
				conv_end_request_flag_reg <= 1'b0;
			if (conv_start)
				conv_start_flag_reg <= 1'b1;
			else if (sw_abort | conv_done | in_standby)
				conv_start_flag_reg <= 1'b0;
		end
	end

	// result registers carry no reset so they survive it
	always_ff @(posedge CLK_SYS) begin
		if (CE && conv_done) begin
			result_reg.high <= conv_code[9:2];
			result_reg.low <= conv_code[1:0];
		end
	end

	// registered pin outputs
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			DAC_CODE <= 10'h000;
			CHANNEL_SEL <= 8'h00;
			CONV_MODULE_STANDBY <= 1'b0;
			CONV_END_IRQ <= 1'b0;
		end else if (CE) begin
			DAC_CODE <= dac_trial;
			CHANNEL_SEL <= channel_next;
			CONV_MODULE_STANDBY <= in_standby;
			CONV_END_IRQ <= irq_next;
		end
	end

endmodule

/* sac_conv_ctrl_tb.sv */
// self-checking testbench of the converter control block
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_conv_ctrl_tb;
	logic clk_sys = 1'b0, rst_n = 1'b0, pin = 1'b0, ce = 1'b1, comp;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, chsel;
	logic [31:0] wdata = 32'h0, rdata;
	logic [79:0] levels = 80'h0;
	logic awready, wready, bvalid, arready, rvalid, stby, irq;
	logic [1:0] bresp, rresp;
	logic [9:0] dac;
	int fail_count = 0, n_compared = 0, cyc = 0;

	sac_conv_ctrl dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(1'b1), .EXT_TRIGGER_PIN(pin), .COMP_IN(comp),
		.DAC_CODE(dac), .CHANNEL_SEL(chsel), .CONV_MODULE_STANDBY(stby),
		.CONV_END_IRQ(irq));
	sac_analog_model an_u (.levels(levels), .channel_sel(chsel),
		.dac_code(dac), .comp_out(comp));

	always #2.5 clk_sys = ~clk_sys;

	task automatic final_report();
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic chk8(input string nm, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, d);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw_p || w_p) begin
			@(posedge clk_sys);
			if (aw_p && awready) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wready) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (bvalid !== 1'b1);
		chk8("bresp", 8'(`SAC_RESP_OKAY), 8'(bresp));
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		d = rdata[7:0];
		r = rresp;
	endtask

	task automatic rc(input string nm, input logic [7:0] a, e, m);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk8(nm, e, d & m);
	endtask

	task automatic end_conv();
		do @(posedge clk_sys); while (irq !== 1'b1);
		wr(`SAC_OFS_IRQ_REQ, 8'h00);
	endtask

	task automatic conv(input logic [7:0] mode, input int lo, hi,
		input logic [9:0] lvl);
		int n;
		levels[19:10] <= lvl;
		wr(`SAC_OFS_MODE, mode);
		wr(`SAC_OFS_START, 8'h80);
		rc("busy", `SAC_OFS_START, 8'hff, 8'hff);
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		chk8("period", 8'h01, 8'(n >= lo && n <= hi));
		rc("idle", `SAC_OFS_START, 8'h7f, 8'hff);
		rc("res high", `SAC_OFS_RES_HIGH, lvl[9:2], 8'hff);
		rc("res low", `SAC_OFS_RES_LOW, {lvl[1:0], 6'h00}, 8'hff);
		rc("req", `SAC_OFS_IRQ_REQ, 8'h08, 8'h08);
		wr(`SAC_OFS_IRQ_EN, 8'h00);
		@(posedge clk_sys);
		chk8("masked", 8'h00, 8'(irq));
		wr(`SAC_OFS_IRQ_EN, 8'h08);
		@(posedge clk_sys);
		chk8("unmasked", 8'h01, 8'(irq));
		wr(`SAC_OFS_IRQ_REQ, 8'h00);
		rc("req clr", `SAC_OFS_IRQ_REQ, 8'h00, 8'h08);
		chk8("irq clr", 8'h00, 8'(irq));
	endtask

	task automatic t_reset();
		logic [7:0] d;
		logic [1:0] r;
		rc("mode rst", `SAC_OFS_MODE, 8'h30, 8'hff);
		rc("start rst", `SAC_OFS_START, 8'h7f, 8'hff);
		rc("stop rst", `SAC_OFS_CLK_STOP, 8'h10, 8'h10);
		chk8("stby rst", 8'h00, 8'(stby));
		rd(8'h40, d, r);
		chk8("unmapped", 8'(`SAC_RESP_SLVERR), 8'(r));
	endtask

	task automatic t_channels();
		for (int c = 0; c < 16; c++) begin
			wr(`SAC_OFS_MODE, c[7:0]);
			@(posedge clk_sys);
			chk8("chan", (c < 4 || c > 11) ? 8'h00 : 8'(1 << (c - 4)),
				chsel);
		end
	endtask

	task automatic t_abort();
		wr(`SAC_OFS_START, 8'h80);
		repeat (10) @(posedge clk_sys);
		wr(`SAC_OFS_START, 8'h00);
		rc("abort", `SAC_OFS_START, 8'h7f, 8'hff);
		repeat (80) @(posedge clk_sys);
		rc("no req", `SAC_OFS_IRQ_REQ, 8'h00, 8'h08);
	endtask

	// a frozen clock enable must hold a running conversion past its period
	task automatic t_freeze();
		wr(`SAC_OFS_START, 8'h80);
		ce <= 1'b0;
		repeat (40) @(posedge clk_sys);
		chk8("frozen irq", 8'h00, 8'(irq));
		ce <= 1'b1;
		rc("held", `SAC_OFS_START, 8'h80, 8'h80);
		end_conv();
	endtask

	task automatic t_trigger();
		wr(`SAC_OFS_PORT_MODE, 8'h10);
		wr(`SAC_OFS_MODE, 8'h05);
		wr(`SAC_OFS_EDGE_SEL, 8'h00);
		pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		pin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rc("trg off", `SAC_OFS_START, 8'h00, 8'h80);
		wr(`SAC_OFS_MODE, 8'h45);
		pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rc("wrong edge", `SAC_OFS_START, 8'h00, 8'h80);
		pin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rc("trg fall", `SAC_OFS_START, 8'h80, 8'h80);
		end_conv();
		wr(`SAC_OFS_EDGE_SEL, 8'h10);
		pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rc("trg rise", `SAC_OFS_START, 8'h80, 8'h80);
		end_conv();
	endtask

	task automatic t_standby();
		wr(`SAC_OFS_CLK_STOP, 8'hef);
		@(posedge clk_sys);
		chk8("stby on", 8'h01, 8'(stby));
		wr(`SAC_OFS_START, 8'h80);
		rc("stby start", `SAC_OFS_START, 8'h00, 8'h80);
		wr(`SAC_OFS_CLK_STOP, 8'hff);
		@(posedge clk_sys);
		chk8("stby off", 8'h00, 8'(stby));
		repeat (10) @(posedge clk_sys);
		conv(8'h05, 52, 64, 10'h3ff);
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_channels();
		wr(`SAC_OFS_IRQ_EN, 8'h08);
		conv(8'h05, 52, 64, 10'h2d7);
		conv(8'h85, 21, 33, 10'h13a);
		t_abort();
		t_freeze();
		t_trigger();
		t_standby();
		final_report();
	end
endmodule

/* sac_conv_monitor.sv */
// concurrent checks on the converter control ports
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_conv_monitor (
	input wire logic CLK_SYS, // system clock
	input wire logic RST_N, // reset, active low
	input wire logic [7:0] S_AXI_ARADDR, // read address
	input wire logic S_AXI_ARVALID, // read address valid
	input wire logic S_AXI_ARREADY, // read address ready
	input wire logic [31:0] S_AXI_RDATA, // read data
	input wire logic [1:0] S_AXI_RRESP, // read response
	input wire logic S_AXI_RVALID, // read data valid
	input wire logic S_AXI_AWVALID, // write address valid
	input wire logic S_AXI_AWREADY, // write address ready
	input wire logic S_AXI_BVALID, // write response valid
	input wire logic [9:0] DAC_CODE, // trial code
	input wire logic [7:0] CHANNEL_SEL, // input routing
	input wire logic CONV_MODULE_STANDBY, // standby level
	input wire logic CONV_END_IRQ // end interrupt
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	logic [7:0] rd_addr_reg;
	always_ff @(posedge CLK_SYS) begin
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rd_addr_reg <= S_AXI_ARADDR;
		end
	end
	property p_rd_answer;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read late");
	property p_wr_answer;
		S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:4] S_AXI_BVALID;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write late");
	property p_start_ones;
		S_AXI_RVALID && rd_addr_reg == `SAC_OFS_START |->
			S_AXI_RDATA[6:0] == 7'h7f && S_AXI_RDATA[31:8] == 24'h000000;
	endproperty
	a_start_ones: assert property (p_start_ones) else $error("start bits");
	property p_low_pad;
		S_AXI_RVALID && rd_addr_reg == `SAC_OFS_RES_LOW |->
			S_AXI_RDATA[5:0] == 6'h00;
	endproperty
	a_low_pad: assert property (p_low_pad) else $error("result low pad");
	property p_mode_ones;
		S_AXI_RVALID && rd_addr_reg == `SAC_OFS_MODE |->
			S_AXI_RDATA[5:4] == 2'h3;
	endproperty
	a_mode_ones: assert property (p_mode_ones) else $error("mode bits");
	property p_unmapped;
		S_AXI_RVALID && rd_addr_reg > `SAC_OFS_IRQ_EN |->
			S_AXI_RRESP == `SAC_RESP_SLVERR && S_AXI_RDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_onehot;
		$onehot0(CHANNEL_SEL);
	endproperty
	a_onehot: assert property (p_onehot) else $error("routing");
	property p_standby_quiet;
		CONV_MODULE_STANDBY [*4] |-> $stable(DAC_CODE);
	endproperty
	a_standby_quiet: assert property (p_standby_quiet) else $error("dac");
	c_irq: cover property ($rose(CONV_END_IRQ));
	c_standby: cover property (CONV_MODULE_STANDBY [*4]);
	c_low: cover property (S_AXI_RVALID && rd_addr_reg == `SAC_OFS_RES_LOW);
endmodule

bind sac_conv_ctrl sac_conv_monitor mon_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_BVALID(S_AXI_BVALID), .DAC_CODE(DAC_CODE),
	.CHANNEL_SEL(CHANNEL_SEL), .CONV_MODULE_STANDBY(CONV_MODULE_STANDBY),
	.CONV_END_IRQ(CONV_END_IRQ));

/* sac_pkg.sv */
// shared types of the converter control block
package sac_pkg;

	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_SAMPLE = 2'b01,
		SAC_CONVERT = 2'b10
	} sac_state_e;

	typedef struct packed {
		logic [7:0] high;
		logic [1:0] low;
	} sac_result_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic strobe;
	} sac_wreq_s;

endpackage

/* sac_sar_engine.sv */
// successive-approximation sequencer producing a ten-bit code
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_sar_engine (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic ce, // clock enable
	input wire logic start, // begin a conversion
	input wire logic abort, // stop and return to idle
	input wire logic fast, // 1 selects the short period
	input wire logic comp_in, // comparator: input at or above trial
	output logic [9:0] trial, // next trial code, registered at the dac
	output logic done, // one-cycle completion pulse
	output logic [9:0] code // final code, valid with done
);

	sac_pkg::sac_state_e state_reg;
	sac_pkg::sac_state_e state_next;
	logic [5:0] cnt_reg;
	logic [5:0] sample_last;
	logic [9:0] mask_reg;
	logic [9:0] decided;
	logic [9:0] trial_reg;
	logic [9:0] trial_next;

	// sampling fills the period around ten bit steps and two handover edges
	assign sample_last = (fast ? `SAC_PERIOD_FAST : `SAC_PERIOD_SLOW) -
		6'h0c;
	assign decided = comp_in ? trial_reg : (trial_reg & ~mask_reg);
	assign code = decided;
	// the dac register loads this same value, so the comparator always
	// judges the trial that the decision is built from
	assign trial = trial_next;

	always_comb begin
		trial_next = trial_reg;
		if (state_reg == sac_pkg::SAC_CONVERT && !mask_reg[0])
			trial_next = decided | (mask_reg >> 1);
		else if (state_reg != sac_pkg::SAC_CONVERT)
			trial_next = 10'h200;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sac_pkg::SAC_IDLE: begin
				if (start)
					state_next = sac_pkg::SAC_SAMPLE;
			end
			sac_pkg::SAC_SAMPLE: begin
				if (cnt_reg == sample_last)
					state_next = sac_pkg::SAC_CONVERT;
			end
			sac_pkg::SAC_CONVERT: begin
				if (mask_reg[0])
					state_next = sac_pkg::SAC_IDLE;
			end
			default: state_next = sac_pkg::SAC_IDLE;
		endcase
		if (abort)
			state_next = sac_pkg::SAC_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= sac_pkg::SAC_IDLE;
			cnt_reg <= 6'h00;
			mask_reg <= 10'h200;
			trial_reg <= 10'h000;
			done <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			trial_reg <= trial_next;
			done <= !abort && state_reg == sac_pkg::SAC_CONVERT &&
				mask_reg[0];
			if (state_reg != sac_pkg::SAC_SAMPLE)
				cnt_reg <= 6'h00;
			else
				cnt_reg <= cnt_reg + 6'h01;
			if (state_reg == sac_pkg::SAC_CONVERT && !mask_reg[0])
				mask_reg <= mask_reg >> 1;
			else if (state_reg != sac_pkg::SAC_CONVERT)
				mask_reg <= 10'h200;
		end
	end

endmodule

/* sac_trigger_edge.sv */
// trigger pin synchroniser and selectable edge detector
`timescale 1ns/10ps
`include "sac_consts.svh"

module sac_trigger_edge (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic ce, // clock enable
	input wire logic pin, // raw trigger pin
	input wire logic rising_sel, // 1 selects rising, 0 falling
	input wire logic enable, // detection allowed
	output logic edge_pulse // one-cycle start request
);

	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;
	logic edge_next;

	assign edge_next = enable & (rising_sel ? (sync2_reg & ~prev_reg) :
		(~sync2_reg & prev_reg));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
			edge_pulse <= 1'b0;
		end else if (ce) begin
			sync1_reg <= pin;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
			edge_pulse <= edge_next;
		end
	end

endmodule
